// file: rtl/spi_cmd_pkg.sv
package spi_cmd_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int FRAME_BITS = 32;
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 28;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 16;
    localparam int WDATA_MSB = 15;
    localparam int WDATA_LSB = 8;
    localparam int CRC_MSB = 7;
    localparam int ST_MSB = 27;
    localparam int ST_LSB = 26;
    localparam int SD_MSB = 25;
    localparam int SD_LSB = 14;
    localparam int SF_MSB = 9;
    localparam int SF_LSB = 8;

    // ****************************************
    // Command and response codes
    // ****************************************
    localparam logic [3:0] CMD_READ = 4'hC;
    localparam logic [3:0] CMD_WRITE = 4'h8;
    localparam logic [3:0] RSP_READ = 4'h6;
    localparam logic [3:0] RSP_WRITE = 4'h4;
    localparam logic [1:0] ST_ERROR = 2'h3;

    // ****************************************
    // CRC and reset values
    // ****************************************
    localparam logic [7:0] CRC_POLY = 8'h2F;
    localparam logic [7:0] CRC_SEED_DEF = 8'hFF;
    localparam logic [7:0] LOCK_REG_ADDR_DEF = 8'h14;
    localparam logic [7:0] RESET_BITS_MASK_DEF = 8'h03;
    localparam logic [31:0] RESP_RESET = 32'h0C00_0000;
    localparam logic [5:0] COUNT_RESET = 6'h00;

    typedef enum logic {
        IDLE = 1'b0,
        DECIDE = 1'b1
    } core_state_type;

    // Core-domain state
    typedef struct packed {
        logic csSync1;
        logic csSync2;
        logic csPrev;
        core_state_type state;
        logic [31:0] cmd;
        logic [5:0] count;
        logic [31:0] resp;
        logic sensorPend;
        logic [7:0] regAddr;
        logic [2:0] sensorSrc;
        logic wrEn;
        logic [7:0] wrData;
        logic [7:0] wrMask;
        logic cmdErr;
    } core_regs_type;

    // Link receive side, falling edge
    typedef struct packed {
        logic [31:0] shift;
        logic [5:0] count;
    } rx_regs_type;

    // Link transmit side, rising edge
    typedef struct packed {
        logic [5:0] index;
        logic miso;
        logic misoEn;
    } tx_regs_type;

endpackage : spi_cmd_pkg

// file: rtl/spi_register_access_commands.sv
// Contract
// - Frames are 32 bits, bit 31 sent first, bit 0 last.
// - Read answer: 0110, status 27:26, zeros, data 23:8, CRC.
// - Odd address byte in 23:16, even address byte in 15:8.
// - Accepted write stores data byte at full 8-bit address.
// - Write only without SPI, output or address error and lock clear.
// - Software-reset bits of lock register stay writable under lock.
// - Failed write changes nothing and returns error response.
// - Write applied only after its frame has completely ended.
// - Write to read-only register: no change, normal response.
// - Write answer: 0100, status, zeros, word bytes 23:8, CRC.
// - Sensor answer in next frame, same error handling as others (code keeps sensor data in error answers).
// - Sensor value captured at chip-select fall of answer frame.
// - Read answered normally only without SPI or output errors.
// - Read data captured at chip-select rise ending command frame.
// - CRC-8 over all 32 command bits; mismatch gives error response.
`timescale 1ns/1ps
module spi_register_access_commands
    import spi_cmd_pkg::*;
#(
    parameter logic [7:0] CRC_SEED = CRC_SEED_DEF,
    parameter logic [7:0] LOCK_REG_ADDR = LOCK_REG_ADDR_DEF,
    parameter logic [7:0] RESET_BITS_MASK = RESET_BITS_MASK_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Link pins
    input wire logic linkSclk,
    input wire logic csN,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    // Register file
    output logic [7:0] regAddr,
    input wire logic [15:0] regRdData,
    input wire logic regAddrMapped,
    input wire logic regAddrReadOnly,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic [7:0] regWrMask,
    // Device state
    input wire logic initCompleteLock,
    input wire logic misoVerifyErr,
    input wire logic [1:0] basicStatus,
    input wire logic [1:0] detailStatus,
    // Sensor data
    output logic [2:0] sensorSrc,
    input wire logic [11:0] sensorData,
    // Events
    output logic cmdErr
);

    // ****************************************
    // Parameter checks
    // ****************************************
    // No reset bit would stay writable under the lock
    if (RESET_BITS_MASK == 8'h00) begin : gen_mask_check
        $error("RESET_BITS_MASK must select at least one bit");
    end

    // ****************************************
    // Link domain
    // ****************************************
    rx_regs_type rxQ;
    rx_regs_type rxD;
    tx_regs_type txQ;
    tx_regs_type txD;
    core_regs_type coreQ;
    core_regs_type coreD;
    logic linkRst;
    logic rxRst;

    // Frame boundary clears the transmit side; clock stopped outside
    assign linkRst = !arst_n || csN;

    // Receive side kept past frame end until the command is taken
    assign rxRst = !arst_n || (coreQ.state == DECIDE);

    // ****************************************
    // Link receive
    // ****************************************
    // MSB first in
    always_comb begin
        rxD.shift = {rxQ.shift[30:0], mosi};
        rxD.count = (rxQ.count == 6'h3F) ? rxQ.count
                                         : rxQ.count + 6'h01;
    end

    // Host launches on rising edge; sampled here on falling edge
    always_ff @(negedge linkSclk or posedge rxRst) begin
        if (rxRst) begin
            rxQ.count <= COUNT_RESET;
            rxQ.shift <= 32'h0000_0000;
        end else begin
            rxQ <= rxD;
        end
    end

    // ****************************************
    // Link transmit
    // ****************************************
    // MSB first out
    always_comb begin
        txD.misoEn = 1'b1;
        txD.index = (txQ.index == 6'h3F) ? txQ.index
                                         : txQ.index + 6'h01;
        if (txQ.index < 6'(FRAME_BITS)) begin
            txD.miso = coreQ.resp[5'(CMD_MSB) - txQ.index[4:0]];
        end else begin
            txD.miso = 1'b0;
        end
    end

    always_ff @(posedge linkSclk or posedge linkRst) begin
        if (linkRst) begin
            txQ.index <= COUNT_RESET;
            txQ.miso <= 1'b0;
            txQ.misoEn <= 1'b0;
        end else begin
            txQ <= txD;
        end
    end

    assign misoOut = txQ.miso;
    assign misoOe = txQ.misoEn;

    // ****************************************
    // Check sum
    // ****************************************
    // Serial CRC: seed in register, message shifted in MSB first
    function automatic logic [7:0] crc8_calc(input logic [31:0] word,
                                             input logic [7:0] seed);
        logic [7:0] r;
        logic fb;
        r = seed;
        for (int i = 31; i >= 0; i--) begin
            fb = r[7];
            r = {r[6:0], word[i]};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction : crc8_calc

    // ****************************************
    // Core domain
    // ****************************************
    function automatic logic [31:0] seal(input logic [31:0] w,
                                         input logic [7:0] seed);
        return {w[31:8], crc8_calc({w[31:8], 8'h00}, seed)};
    endfunction : seal

    logic csRise;
    logic csFall;
    logic spiErr;
    logic anyErr;
    logic lockExempt;
    logic [3:0] code;
    logic [3:0] rspCode;
    logic [31:0] word;

    always_comb begin
        coreD = coreQ;
        coreD.csSync1 = csN;
        coreD.csSync2 = coreQ.csSync1;
        coreD.csPrev = coreQ.csSync2;
        coreD.wrEn = 1'b0;
        coreD.cmdErr = 1'b0;
        csRise = coreQ.csSync2 && !coreQ.csPrev;
        csFall = !coreQ.csSync2 && coreQ.csPrev;
        code = coreQ.cmd[CMD_MSB:CMD_LSB];
        spiErr = (crc8_calc(coreQ.cmd, CRC_SEED) != 8'h00)
                 || (coreQ.count != 6'(FRAME_BITS));
        anyErr = spiErr || misoVerifyErr;
        lockExempt = coreQ.regAddr == LOCK_REG_ADDR;
        rspCode = {code[0], code[3:1]};
        word = 32'h0000_0000;
        case (coreQ.state)
            IDLE: begin
                if (csRise) begin
                    coreD.cmd = rxQ.shift;
                    coreD.count = rxQ.count;
                    coreD.regAddr = rxQ.shift[ADDR_MSB:ADDR_LSB];
                    coreD.sensorPend = 1'b0;
                    coreD.state = DECIDE;
                end
            end
            DECIDE: begin
                coreD.state = IDLE;
                word[CMD_MSB:CMD_LSB] = rspCode;
                word[ST_MSB:ST_LSB] = basicStatus;
                if (code == CMD_READ) begin
                    word[CMD_MSB:CMD_LSB] = RSP_READ;
                    // odd byte high, even byte low
                    word[ADDR_MSB:WDATA_LSB] = regRdData;
                    if (anyErr) begin
                        word = 32'h0000_0000;
                        word[CMD_MSB:CMD_LSB] = RSP_READ;
                        word[ST_MSB:ST_LSB] = ST_ERROR;
                        word[SF_MSB:SF_LSB] = detailStatus;
                    end
                end else if (code == CMD_WRITE) begin
                    word[CMD_MSB:CMD_LSB] = RSP_WRITE;
                    word[ADDR_MSB:WDATA_LSB] = regRdData;
                    if (anyErr || !regAddrMapped
                        || (initCompleteLock && !lockExempt)) begin
                        word = 32'h0000_0000;
                        word[CMD_MSB:CMD_LSB] = RSP_WRITE;
                        word[ST_MSB:ST_LSB] = ST_ERROR;
                        word[SF_MSB:SF_LSB] = detailStatus;
                    end else if (!regAddrReadOnly) begin
                        coreD.wrEn = 1'b1;
                        coreD.wrData = coreQ.cmd[WDATA_MSB:WDATA_LSB];
                        coreD.wrMask = initCompleteLock ? RESET_BITS_MASK
                                                        : 8'hFF;
                    end
                end else if (code[0]) begin
                    coreD.sensorPend = 1'b1;
                    coreD.sensorSrc = code[3:1];
                    word[SF_MSB:SF_LSB] = detailStatus;
                    if (anyErr) begin
                        word[ST_MSB:ST_LSB] = ST_ERROR;
                    end
                end else begin
                    // Reserved codes get the error form
                    word[ST_MSB:ST_LSB] = ST_ERROR;
                    word[SF_MSB:SF_LSB] = detailStatus;
                end
                coreD.cmdErr = anyErr;
                coreD.resp = seal(word, CRC_SEED);
            end
            default: begin
                coreD.state = IDLE;
            end
        endcase
        // sensor value at start of answer frame
        if (csFall && coreQ.sensorPend) begin
            coreD.sensorPend = 1'b0;
            word = coreQ.resp;
            word[SD_MSB:SD_LSB] = sensorData;
            coreD.resp = seal(word, CRC_SEED);
        end
    end

    // ****************************************
    // Core registers
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            coreQ.csSync1 <= 1'b1;
            coreQ.csSync2 <= 1'b1;
            coreQ.csPrev <= 1'b1;
            coreQ.state <= IDLE;
            coreQ.cmd <= 32'h0000_0000;
            coreQ.count <= COUNT_RESET;
            coreQ.resp <= RESP_RESET;
            coreQ.sensorPend <= 1'b0;
            coreQ.regAddr <= 8'h00;
            coreQ.sensorSrc <= 3'h0;
            coreQ.wrEn <= 1'b0;
            coreQ.wrData <= 8'h00;
            coreQ.wrMask <= 8'h00;
            coreQ.cmdErr <= 1'b0;
        end else begin
            coreQ <= coreD;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign regAddr = coreQ.regAddr;
    assign regWrEn = coreQ.wrEn;
    assign regWrData = coreQ.wrData;
    assign regWrMask = coreQ.wrMask;
    assign sensorSrc = coreQ.sensorSrc;
    assign cmdErr = coreQ.cmdErr;

endmodule : spi_register_access_commands

// file: verification/spi_cmd_checker.sv
`timescale 1ns/1ps
module spi_cmd_checker
    import spi_cmd_pkg::*;
#(
    parameter logic [7:0] LOCK_REG_ADDR = LOCK_REG_ADDR_DEF,
    parameter logic [7:0] RESET_BITS_MASK = RESET_BITS_MASK_DEF
) (
    // Watched ports
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic misoOe,
    input wire logic [7:0] regAddr,
    input wire logic regAddrMapped,
    input wire logic regAddrReadOnly,
    input wire logic regWrEn,
    input wire logic [7:0] regWrMask,
    input wire logic initCompleteLock,
    input wire logic cmdErr
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    // ****************************************
    // Write, error and output-enable checks
    // ****************************************
    chk_lock_blocks: assert property (regWrEn && initCompleteLock |->
        regAddr == LOCK_REG_ADDR) else $error("write passed the lock");
    chk_mask_lock: assert property (regWrEn && initCompleteLock |->
        regWrMask == RESET_BITS_MASK) else $error("bad mask under lock");
    chk_mask_full: assert property (regWrEn && !initCompleteLock |->
        regWrMask == 8'hFF) else $error("bad write mask");
    chk_wr_mapped: assert property (regWrEn |->
        regAddrMapped && !regAddrReadOnly) else $error("bad write target");
    chk_wr_after: assert property (regWrEn |->
        csN && $past(csN, 3)) else $error("write inside a frame");
    chk_wr_pulse: assert property (regWrEn |=>
        !regWrEn) else $error("write pulse too long");
    chk_err_nowr: assert property (cmdErr |->
        !regWrEn) else $error("write on error");
    chk_err_after: assert property (cmdErr |->
        $past(csN, 3) && csN) else $error("error flag inside frame");
    chk_oe_idle: assert property (csN |->
        !misoOe) else $error("output driven outside frame");
    cover property (regWrEn && initCompleteLock);
    cover property (regWrEn && !initCompleteLock);
    cover property (cmdErr);
endmodule : spi_cmd_checker

bind spi_register_access_commands spi_cmd_checker #(
    .LOCK_REG_ADDR(LOCK_REG_ADDR),
    .RESET_BITS_MASK(RESET_BITS_MASK)
) i_checker (.core_clk, .arst_n, .csN, .misoOe, .regAddr, .regAddrMapped,
    .regAddrReadOnly, .regWrEn, .regWrMask, .initCompleteLock, .cmdErr);

// file: verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // Link pins
    output logic linkSclk,
    output logic csN,
    output logic mosi,
    input wire logic misoOut,
    input wire logic misoOe
);
    initial begin
        linkSclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end
    task automatic frame(input logic [31:0] cmd, output logic [31:0] rsp);
        csN = 1'b0;
        #217;
        for (int i = 31; i >= 0; i--) begin
            #7 mosi = cmd[i];
            #8 linkSclk = 1'b1;
            #15 linkSclk = 1'b0;
            rsp[i] = misoOe ? misoOut : 1'bx;
        end
        #13 csN = 1'b1;
        mosi = ~mosi;
        #263;
    endtask : frame
endmodule : spi_host_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import spi_cmd_pkg::*;
    logic core_clk, arst_n, linkSclk, csN, mosi, misoOut, misoOe;
    logic regAddrMapped, regAddrReadOnly, regWrEn, cmdErr;
    logic initCompleteLock, misoVerifyErr;
    logic [1:0] basicStatus, detailStatus, pKind, pSt, pSf;
    logic [2:0] sensorSrc;
    logic [3:0] pCode;
    logic [7:0] regAddr, regWrData, regWrMask, lfsr, a;
    logic [11:0] sensorData;
    logic [15:0] regRdData, pData;
    logic [7:0] regs [256];
    logic [7:0] model [256];
    int fail_count, comparisons, errPulses;
    // ****************************************
    // Clock, register file, blocks
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    assign regRdData = {regs[{regAddr[7:1], 1'b1}],
        regs[{regAddr[7:1], 1'b0}]};
    assign regAddrMapped = regAddr < 8'h40;
    assign regAddrReadOnly = regAddr >= 8'h30;
    always @(posedge core_clk) begin
        if (regWrEn) begin
            regs[regAddr] <= (regs[regAddr] & ~regWrMask)
                | (regWrData & regWrMask);
        end
    end
    always @(posedge core_clk) begin
        if (cmdErr === 1'b1) begin
            errPulses++;
        end
    end
    spi_register_access_commands i_dut (.core_clk, .arst_n, .linkSclk, .csN,
        .mosi, .misoOut, .misoOe, .regAddr, .regRdData, .regAddrMapped,
        .regAddrReadOnly, .regWrEn, .regWrData, .regWrMask, .initCompleteLock,
        .misoVerifyErr, .basicStatus, .detailStatus, .sensorSrc, .sensorData,
        .cmdErr);
    spi_host_model i_host (.linkSclk, .csN, .mosi, .misoOut, .misoOe);
    function automatic logic [7:0] nextRand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nextRand
    function automatic logic [31:0] seal(input logic [31:0] w);
        logic [7:0] r;
        r = 8'hFF;
        for (int i = 31; i >= 8; i--) begin
            r = {r[6:0], w[i]} ^ (r[7] ? 8'h2F : 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            r = {r[6:0], 1'b0} ^ (r[7] ? 8'h2F : 8'h00);
        end
        return {w[31:8], r};
    endfunction : seal
    function automatic logic [31:0] expRsp();
        case (pKind)
            2'h0: return seal({pCode, pSt, 2'h0, pData, 8'h00});
            2'h1: return seal({pCode, 2'h3, 16'h0000, pSf, 8'h00});
            2'h2: return seal({pCode, pSt, sensorData, 4'h0, pSf, 8'h00});
            default: return RESP_RESET;
        endcase
    endfunction : expRsp
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic xfer(input logic [31:0] cmd, input logic [1:0] kind,
                        input logic [15:0] data);
        logic [31:0] rsp;
        logic [31:0] exp;
        @(negedge core_clk);
        lfsr = nextRand(lfsr);
        {detailStatus, basicStatus} = lfsr[3:0];
        sensorData = {lfsr[3:0], nextRand(lfsr)};
        exp = expRsp();
        i_host.frame(cmd, rsp);
        check("response", rsp, exp);
        {pKind, pSt, pSf, pData} = {kind, basicStatus, detailStatus, data};
        pCode = {cmd[28], cmd[31:29]};
        $display("test frame %h done", cmd);
    endtask : xfer
    task automatic wr(input logic [7:0] ad, input logic [7:0] d,
                      input logic [7:0] m, input logic [1:0] k);
        xfer(seal({CMD_WRITE, 4'h0, ad, d, 8'h00}), k,
            {model[{ad[7:1], 1'b1}], model[{ad[7:1], 1'b0}]});
        model[ad] = (model[ad] & ~m) | (d & m);
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [1:0] k);
        xfer(seal({CMD_READ, 4'h0, ad, 16'h0000}), k,
            {model[{ad[7:1], 1'b1}], model[{ad[7:1], 1'b0}]});
    endtask : rd
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
    initial begin
        {arst_n, initCompleteLock, misoVerifyErr} = 3'h0;
        {basicStatus, detailStatus, sensorData} = 16'h0000;
        {lfsr, pKind, fail_count, comparisons} = {8'h4A, 2'h3, 64'h0};
        errPulses = 0;
        for (int i = 0; i < 256; i++) begin
            {regs[i], model[i]} = 16'h0000;
        end
        repeat (6) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        rd(8'h20, 2'h0);
        wr(8'h21, 8'hA5, 8'hFF, 2'h0);
        for (int n = 0; n < 8; n++) begin
            a = lfsr % 8'h30;
            wr(a, nextRand(lfsr), 8'hFF, 2'h0);
            rd(a, 2'h0);
        end
        @(negedge core_clk) initCompleteLock = 1'b1;
        wr(8'h10, 8'h5A, 8'h00, 2'h1);
        wr(LOCK_REG_ADDR_DEF, 8'hFF, RESET_BITS_MASK_DEF, 2'h0);
        rd(LOCK_REG_ADDR_DEF, 2'h0);
        @(negedge core_clk) initCompleteLock = 1'b0;
        rd(8'h10, 2'h0);
        wr(8'h80, 8'h11, 8'h00, 2'h1);
        wr(8'h31, 8'h22, 8'h00, 2'h0);
        rd(8'h31, 2'h0);
        @(negedge core_clk) misoVerifyErr = 1'b1;
        rd(8'h02, 2'h1);
        wr(8'h02, 8'h33, 8'h00, 2'h1);
        @(negedge core_clk) misoVerifyErr = 1'b0;
        xfer(seal({CMD_READ, 28'h000_0000}) ^ 32'h0000_0001, 2'h1, 16'h0000);
        rd(8'h02, 2'h0);
        for (int s = 0; s < 8; s++) begin
            xfer(seal({s[2:0], 1'b1, 28'h000_0000}), 2'h2, 16'h0000);
            check("sensorSrc", {29'h0000_0000, sensorSrc}, s);
        end
        rd(8'h21, 2'h0);
        check("cmdErr", errPulses, 32'h0000_0003);
        summarize();
    end
endmodule : tb_top
